// file: hdl/ams_pkg.sv
// constants and types shared by the adc mode sequencer
package ams_pkg;
  // mode field encodings
  localparam logic [2:0] MODE_CONT = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
  localparam logic [2:0] MODE_STBY = 3'h2;
  localparam logic [2:0] MODE_PDWN = 3'h3;
  localparam logic [2:0] MODE_ICAL_ZERO = 3'h4;
  localparam logic [2:0] MODE_ICAL_FULL = 3'h5;
  localparam logic [2:0] MODE_SCAL_ZERO = 3'h6;
  localparam logic [2:0] MODE_SCAL_FULL = 3'h7;
  // clock source select: internal oscillator
  localparam logic [1:0] CLKSEL_INT_OSC = 2'h0;
  // serial interface
  localparam logic [7:0] CMD_READ_DATA = 8'h44;
  localparam logic [6:0] RESET_CLKS = 7'h40;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] WORD_BITS = 6'h18;
  localparam logic [5:0] WORD_STAT_BITS = 6'h20;
  // status byte layout
  localparam int STAT_RDY_BIT = 7;
  localparam int STAT_CHAN_LSB = 0;
  // calibration coefficients and scaling
  localparam logic [23:0] OFFSET_RST = 24'h800000;
  localparam logic [23:0] GAIN_RST = 24'h555555;
  localparam logic [23:0] MID_SCALE = 24'h800000;
  localparam int GAIN_SHIFT = 22;
  localparam logic [51:0] FS_GAIN_NUM = 52'h1fffffc00000;
  localparam logic [23:0] FS_MAX = 24'hffffff;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_US = 161;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int RESET_WAIT_US = 500;
  localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
  localparam int PRE_LOAD_CYC = 4;
  // conversion engine and serial states
  typedef enum logic [2:0] {CV_IDLE = 3'b001, CV_RUN = 3'b010, CV_PDWN = 3'b100} ams_cv_state_t;
  typedef enum logic [1:0] {SR_CMD = 2'b01, SR_DATA = 2'b10} ams_sr_state_t;
endpackage : ams_pkg

// file: hdl/ams_scale_if.sv
// link between the sequencer and its calibration scaler
`timescale 1ns/1ps
`default_nettype none
interface ams_scale_if;
  logic [23:0] raw;
  logic [23:0] offset;
  logic [23:0] gain;
  logic bipolar;
  logic [23:0] result;
  logic [23:0] cal_offset;
  logic [23:0] cal_gain;
  modport main (output raw, offset, gain, bipolar, input result, cal_offset, cal_gain);
  modport scaler (input raw, offset, gain, bipolar, output result, cal_offset, cal_gain);
endinterface : ams_scale_if
`default_nettype wire

// file: hdl/ams_scaler.sv
// offset and gain scaling of raw codes, plus coefficient calculation
`timescale 1ns/1ps
`default_nettype none
module ams_scaler (
  ams_scale_if.scaler sc
);
  import ams_pkg::*;
  // raw code is two's complement from the modulator
  wire signed [25:0] raw_s = $signed({{2{sc.raw[23]}}, sc.raw});
  wire signed [25:0] off_s = $signed({2'h0, sc.offset}) - $signed({2'h0, MID_SCALE});
  wire signed [25:0] diff_s = raw_s - off_s;
  wire signed [51:0] prod_s = diff_s * $signed({2'h0, sc.gain});
  wire signed [51:0] quot_s = prod_s >>> GAIN_SHIFT;
  wire signed [51:0] mid_s = $signed({28'h0, MID_SCALE});
  // bipolar adds mid-scale, unipolar doubles
  wire signed [51:0] scaled_s = sc.bipolar ? quot_s + mid_s : quot_s <<< 1;
  // clamp instead of wrapping so overrange reads as full scale
  assign sc.result = scaled_s < 0 ? 24'h000000 :
                     (scaled_s > $signed({28'h0, FS_MAX}) ? FS_MAX : scaled_s[23:0]);
  // zero-scale: offset that maps the present input to zero
  assign sc.cal_offset = sc.raw + MID_SCALE;
  // full-scale: gain that maps the present input to the top code
  wire signed [51:0] diff_w = {{26{diff_s[25]}}, diff_s};
  wire [51:0] gain_w = diff_s > 0 ? FS_GAIN_NUM / diff_w : {28'h0, FS_MAX};
  assign sc.cal_gain = gain_w > {28'h0, FS_MAX} ? FS_MAX : gain_w[23:0];
endmodule : ams_scaler
`default_nettype wire

// file: hdl/ams_sequencer.sv
// operating modes, channel sequencing and serial read-out of the adc
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] power-up leaves the converter in continuous conversion, free running
// [R2] each result clears ready bit; pin low only while chip select low
// [R3] full word shifted out raises ready; same word may be read again
// [R4] result finishing during an ordinary data read is dropped
// [R5] enabled channels convert lowest to highest, then wrap; each updates data
// [R6] append_status adds status byte after data; low two bits give channel
// [R7] continuous read shifts data on clocks alone, once per result
// [R8] unread result in continuous read: shifter cleared just before next load
// [R9] continuous read allows data reads only; enabled only in continuous mode
// [R10] continuous read exits on command 0x44 or the 64-clock reset
// [R11] host keeps data-in low in continuous read unless sending commands
// [R12] single mode converts each enabled channel once then enters standby
// [R13] conversion start raises ready until a valid result exists
// [R14] standby keeps registers; internal oscillator selection stops the clock
// [R15] power-down only from standby, loses registers, exits via serial reset
// [R16] three calibration modes; internal full-scale is not offered
// [R17] one channel during calibration; results scaled by offset and gain
// [R18] offset defaults to 0x800000, gain to 0x555555
// [R19] subtract offset less mid-scale, times gain over unity, bipolar or doubled
// [R20] calibration raises ready, then updates coefficient, clears ready, standby
// [R21] internal offset calibration ties modulator inputs to negative input
// [R22] host runs offset before full-scale and polls ready for the end
// [R23] calibration lasts one settling time of the selected filter
// [R24] coefficient access refused while internal calibration runs
// [R25] serial reset restores power-on values; host waits 500 us afterwards
// [R26] new coefficients scale the first result completing after the write
module ams_sequencer #(
  parameter int unsigned SETTLE_CYC = ams_pkg::SETTLE_CYC,
  parameter int unsigned RESET_WAIT_CYC = ams_pkg::RESET_WAIT_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic [2:0] mode_in,
  input wire logic mode_wr_in,
  input wire logic [3:0] chan_en_in,
  input wire logic append_status_in,
  input wire logic cont_read_en_in,
  input wire logic bipolar_in,
  input wire logic [1:0] clock_source_sel_in,
  input wire logic [23:0] raw_code_in,
  input wire logic coef_wr_in,
  input wire logic coef_sel_in,
  input wire logic [23:0] coef_wdata_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic ready_n_out,
  output logic [7:0] status_out,
  output logic [23:0] data_out,
  output logic [23:0] offset_out,
  output logic [23:0] gain_out,
  output logic [2:0] mode_out,
  output logic cont_read_out,
  output logic converting_out,
  output logic short_to_neg_out,
  output logic osc_run_out,
  output logic gpio_tristate_out,
  output logic if_busy_out
);
  import ams_pkg::*;

  // next enabled channel above cur, wrapping; cur when none enabled
  function automatic logic [1:0] next_chan(input logic [3:0] en, input logic [1:0] cur);
    logic [1:0] nxt;
    logic [1:0] idx;
    logic found;
    nxt = cur;
    found = 1'b0;
    for (int i = 1; i <= 4; i++)
    begin
      idx = cur + 2'(i);
      if (!found && en[idx])
      begin
        nxt = idx;
        found = 1'b1;
      end
    end
    return nxt;
  endfunction : next_chan

  // pin synchronisers: stage 1 feeds stage 2 only, stages 2 and 3 must agree
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_filt_q;
  wire [2:0] pin_raw = {din_in, cs_n_in, sclk_in};
  wire [2:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge clk_in)
      begin
        pin_s1_q[g] <= pin_raw[g];
        pin_s2_q[g] <= pin_s1_q[g];
        pin_s3_q[g] <= pin_s2_q[g];
        // reset to idle levels (clock and select high) so no false edge follows reset
        if (srst_in)
          pin_filt_q[g] <= (g != 2);
        else if (pin_agree[g])
          pin_filt_q[g] <= pin_s3_q[g];
      end
    end
  endgenerate
  wire sclk_rise = pin_agree[0] & pin_s3_q[0] & ~pin_filt_q[0];
  wire sclk_fall = pin_agree[0] & ~pin_s3_q[0] & pin_filt_q[0];
  wire cs_low = ~pin_filt_q[1];
  wire din_lvl = pin_filt_q[2];

  // state
  ams_cv_state_t cv_q;
  ams_sr_state_t sr_q;
  logic [2:0] mode_q;
  logic [1:0] chan_q, stat_chan_q;
  logic [23:0] tmr_q, data_q, offset_q, gain_q, wait_q;
  logic [6:0] rst_cnt_q;
  logic soft_rst_q, rdy_n_q, cont_rd_q, cr_en_prev_q;
  logic [5:0] bit_cnt_q;
  logic [7:0] cmd_q;
  logic [31:0] shreg_q;

  // the scaler works on the coefficients as they stand at completion
  ams_scale_if sc_if ();
  ams_scaler u_scaler (.sc(sc_if.scaler));
  assign sc_if.raw = raw_code_in;
  assign sc_if.offset = offset_q; // R26
  assign sc_if.gain = gain_q;
  assign sc_if.bipolar = bipolar_in; // R19

  // serial reset: 64 rising clocks with chip select low and data-in high
  wire rst_hit = sclk_rise & din_lvl & cs_low & (rst_cnt_q == RESET_CLKS - 7'h01);
  wire rst_all = srst_in | soft_rst_q;
  always_ff @(posedge clk_in)
  begin
    if (rst_all || !cs_low || (sclk_rise && !din_lvl))
      rst_cnt_q <= 7'h00;
    else if (sclk_rise)
      rst_cnt_q <= rst_cnt_q + 7'h01;
    soft_rst_q <= !srst_in && rst_hit; // R10 R15 R25
  end

  // interface blanking after a serial reset, while regulators come up
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      wait_q <= 24'h000000;
    else if (soft_rst_q)
      wait_q <= 24'(RESET_WAIT_CYC); // R25
    else if (wait_q != 24'h000000)
      wait_q <= wait_q - 24'h000001;
  end

  // conversion decode
  wire is_cal = mode_q[2];
  wire tmr_done = (cv_q == CV_RUN) && (tmr_q == 24'(SETTLE_CYC - 1)); // R23
  wire tmr_near = (cv_q == CV_RUN) && (tmr_q == 24'(SETTLE_CYC - 1 - PRE_LOAD_CYC));
  wire [1:0] first_ch = next_chan(chan_en_in, 2'h3); // R5
  wire [1:0] nxt_ch = next_chan(chan_en_in, chan_q);
  wire last_ch = nxt_ch <= chan_q;
  wire reading = (sr_q == SR_DATA) && !cont_rd_q;
  wire res_wr = tmr_done && !is_cal && !reading; // R4
  wire cal_done = tmr_done && is_cal;
  wire mode_ok = mode_wr_in && (cv_q != CV_PDWN) && (mode_in != MODE_ICAL_FULL); // R16
  wire pdwn_ok = mode_in != MODE_PDWN || cv_q == CV_IDLE; // R15
  wire start = mode_ok && pdwn_ok && (mode_in != MODE_STBY) && (mode_in != MODE_PDWN);
  wire ical_run = (cv_q == CV_RUN) && (mode_q == MODE_ICAL_ZERO);

  // conversion engine; standby leaves every register as it is
  always_ff @(posedge clk_in)
  begin
    if (rst_all)
    begin
      cv_q <= CV_RUN; // R1
      mode_q <= MODE_CONT;
      chan_q <= 2'h0;
      tmr_q <= 24'h000000;
    end
    else if (mode_ok && pdwn_ok)
    begin
      mode_q <= mode_in;
      chan_q <= first_ch; // R17
      tmr_q <= 24'h000000;
      cv_q <= start ? CV_RUN : (mode_in == MODE_PDWN ? CV_PDWN : CV_IDLE); // R14 R15
    end
    else if (tmr_done)
    begin
      tmr_q <= 24'h000000;
      chan_q <= nxt_ch; // R5
      if (is_cal || (mode_q == MODE_SINGLE && last_ch))
      begin
        cv_q <= CV_IDLE; // R12 R20
        mode_q <= MODE_STBY;
      end
    end
    else if (cv_q == CV_RUN)
      tmr_q <= tmr_q + 24'h000001;
  end

  // coefficients: calibration result wins over a host write
  always_ff @(posedge clk_in)
  begin
    if (rst_all || cv_q == CV_PDWN)
    begin
      offset_q <= OFFSET_RST; // R18
      gain_q <= GAIN_RST;
    end
    else if (cal_done)
    begin
      if (mode_q == MODE_SCAL_FULL)
        gain_q <= sc_if.cal_gain; // R20
      else
        offset_q <= sc_if.cal_offset;
    end
    else if (coef_wr_in && !ical_run) // R24
    begin
      if (coef_sel_in)
        gain_q <= coef_wdata_in;
      else
        offset_q <= coef_wdata_in;
    end
  end

  // data register and ready bit; a finishing ordinary read beats a new result, which is dropped
  wire read_done = (sr_q == SR_DATA) && sclk_rise &&
                   (bit_cnt_q == (append_status_in ? WORD_STAT_BITS : WORD_BITS) - 6'h01);
  always_ff @(posedge clk_in)
  begin
    if (rst_all)
    begin
      data_q <= 24'h000000;
      stat_chan_q <= 2'h0;
      rdy_n_q <= 1'b1;
    end
    else if (res_wr)
    begin
      data_q <= sc_if.result; // R17
      stat_chan_q <= chan_q; // R6
      rdy_n_q <= 1'b0; // R2
    end
    else if (cal_done)
      rdy_n_q <= 1'b0; // R20
    else if (start || read_done || (tmr_near && cont_rd_q))
      rdy_n_q <= 1'b1; // R3 R7 R13
  end

  // continuous read enable follows the rising edge of its control bit
  wire cmd_byte_44 = ({cmd_q[6:0], din_lvl} == CMD_READ_DATA);
  wire byte_end = sclk_rise && (bit_cnt_q[2:0] == 3'h7);
  wire cr_exit = cont_rd_q && byte_end && (bit_cnt_q < CMD_BITS) && cmd_byte_44 && !rdy_n_q;
  always_ff @(posedge clk_in)
  begin
    cr_en_prev_q <= rst_all ? 1'b0 : cont_read_en_in;
    if (rst_all || cr_exit)
      cont_rd_q <= 1'b0; // R10
    else if (cont_read_en_in && !cr_en_prev_q && mode_q == MODE_CONT)
      cont_rd_q <= 1'b1; // R9
  end

  // serial shifter: data leaves msb first, changing on falling clocks
  wire [7:0] stat_byte = {rdy_n_q, 5'h00, stat_chan_q};
  wire [31:0] load_word = {data_q, append_status_in ? stat_byte : 8'h00}; // R6
  wire cr_load = cont_rd_q && (sr_q == SR_CMD) && !rdy_n_q && cs_low; // R7
  wire cmd_load = !cont_rd_q && (sr_q == SR_CMD) && byte_end && cmd_byte_44; // R9
  wire shift_now = sclk_fall && (sr_q == SR_DATA) && (bit_cnt_q != 6'h00);
  // next bit goes out with the shift itself; the pin sync already eats most of a half period
  wire dout_nxt = shift_now ? shreg_q[30] : shreg_q[31];
  always_ff @(posedge clk_in)
  begin
    if (rst_all || !cs_low || wait_q != 24'h000000 || (tmr_near && cont_rd_q)) // R8
    begin
      sr_q <= SR_CMD;
      bit_cnt_q <= 6'h00;
      cmd_q <= 8'h00;
    end
    else if (cr_load || cmd_load)
    begin
      sr_q <= SR_DATA;
      bit_cnt_q <= 6'h00;
      shreg_q <= load_word;
      cmd_q <= 8'h00;
    end
    else if (read_done)
    begin
      sr_q <= SR_CMD; // R3
      bit_cnt_q <= 6'h00;
    end
    else if (sclk_rise)
    begin
      bit_cnt_q <= (sr_q == SR_CMD && byte_end) ? 6'h00 : bit_cnt_q + 6'h01;
      cmd_q <= {cmd_q[6:0], din_lvl};
    end
    else if (shift_now)
      shreg_q <= {shreg_q[30:0], 1'b0};
  end

  // registered outputs
  always_ff @(posedge clk_in)
  begin
    dout_out <= (sr_q == SR_DATA) ? dout_nxt : (rdy_n_q || !cs_low); // R2
    dout_oe_out <= !rst_all && cs_low && cv_q != CV_PDWN;
    ready_n_out <= rdy_n_q;
    status_out <= stat_byte;
    data_out <= data_q;
    offset_out <= offset_q;
    gain_out <= gain_q;
    mode_out <= mode_q;
    cont_read_out <= cont_rd_q;
    converting_out <= cv_q == CV_RUN;
    short_to_neg_out <= ical_run; // R21
    osc_run_out <= (cv_q == CV_RUN) || (cv_q == CV_IDLE && clock_source_sel_in != CLKSEL_INT_OSC); // R14
    gpio_tristate_out <= cv_q == CV_PDWN; // R15
    if_busy_out <= wait_q != 24'h000000;
  end

  // checks
  sequence s_cal_start;
    mode_wr_in && mode_ok && mode_in[2];
  endsequence
  sequence s_cal_end;
    cal_done ##1 (cv_q == CV_IDLE && !rdy_n_q && mode_q == MODE_STBY);
  endsequence
  chk_pwr_up_conv: assert property (@(posedge clk_in) $fell(srst_in) |-> // R1
    cv_q == CV_RUN && mode_q == MODE_CONT) else $error("not converting after reset");
  chk_ready_pin: assert property (@(posedge clk_in) disable iff (srst_in) // R2
    res_wr ##1 (sr_q == SR_CMD && cs_low) |-> !rdy_n_q ##1 !dout_out)
    else $error("ready pin not low after result");
  chk_read_ready: assert property (@(posedge clk_in) disable iff (rst_all) // R3
    read_done && !res_wr && !cal_done |=> rdy_n_q && sr_q == SR_CMD) else $error("ready not raised");
  chk_discard_busy: assert property (@(posedge clk_in) disable iff (rst_all) // R4
    tmr_done && !is_cal && reading |=> $stable(data_q)) else $error("result written mid-read");
  chk_chan_tag: assert property (@(posedge clk_in) disable iff (rst_all) // R5
    res_wr |=> stat_chan_q == $past(chan_q) && chan_q == $past(nxt_ch)) else $error("channel order");
  chk_one_read: assert property (@(posedge clk_in) disable iff (rst_all) // R7
    cont_rd_q && read_done && !res_wr |=> !cr_load) else $error("second read in continuous read");
  chk_pre_abort: assert property (@(posedge clk_in) disable iff (rst_all) // R8
    tmr_near && cont_rd_q |=> sr_q == SR_CMD && rdy_n_q) else $error("shifter not cleared");
  chk_single_end: assert property (@(posedge clk_in) disable iff (rst_all) // R12
    tmr_done && mode_q == MODE_SINGLE && last_ch |=> cv_q == CV_IDLE && mode_q == MODE_STBY)
    else $error("single mode did not stop");
  chk_pdwn_entry: assert property (@(posedge clk_in) disable iff (rst_all) // R15
    $rose(cv_q == CV_PDWN) |-> $past(cv_q) == CV_IDLE) else $error("power-down not from standby");
  chk_cal_flow: assert property (@(posedge clk_in) disable iff (rst_all) // R20
    s_cal_start |=> rdy_n_q && cv_q == CV_RUN) else $error("calibration start wrong");
  chk_cal_done: assert property (@(posedge clk_in) disable iff (rst_all) // R20
    cal_done |-> s_cal_end) else $error("calibration end wrong");
  chk_coef_lock: assert property (@(posedge clk_in) disable iff (rst_all) // R24
    ical_run && !tmr_done |=> $stable(offset_q) && $stable(gain_q)) else $error("coefficient changed");
endmodule : ams_sequencer
`default_nettype wire

// file: sim/ams_host_model.sv
// host side of the four-wire serial port: read, command and reset frames
`timescale 1ns/1ps
`default_nettype none
module ams_host_model (
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out,
  input wire logic dout_in
);
  localparam int HALF_NS = 24;
  // idle: deselected, clock parked high, data-in held low
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    din_out = 1'b0;
  end
  // optional command byte msb first, then nbits of read data sampled at each rise
  task automatic xfer(input logic [7:0] cmd, input bit send_cmd, input int nbits,
                      output logic [31:0] rd);
    rd = '0;
    cs_n_out = 1'b0;
    #(HALF_NS);
    if (send_cmd)
    begin
      for (int i = 0; i < 8; i++)
      begin
        sclk_out = 1'b0;
        din_out = cmd[7-i];
        #(HALF_NS);
        sclk_out = 1'b1;
        #(HALF_NS);
      end
    end
    // data-in back low so no stray command is seen in continuous read
    din_out = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      sclk_out = 1'b0;
      #(HALF_NS);
      rd = {rd[30:0], dout_in};
      sclk_out = 1'b1;
      #(HALF_NS);
    end
    cs_n_out = 1'b1;
    #(HALF_NS);
  endtask : xfer
  // 64 clocks with data-in high; caller then honours the blanking wait
  task automatic sreset();
    cs_n_out = 1'b0;
    din_out = 1'b1;
    repeat (64)
    begin
      sclk_out = 1'b0;
      #(HALF_NS);
      sclk_out = 1'b1;
      #(HALF_NS);
    end
    din_out = 1'b0;
    cs_n_out = 1'b1;
    #(HALF_NS);
  endtask : sreset
endmodule : ams_host_model
`default_nettype wire

// file: sim/ams_sequencer_tb.sv
// self-checking bench for the adc mode sequencer
`timescale 1ns/1ps
`default_nettype none
module ams_sequencer_tb;
  import ams_pkg::*;
  logic clk_in, srst_in, cs_n, sclk, din, dout;
  logic [2:0] mode_in;
  logic mode_wr_in, append_status_in, cont_read_en_in, bipolar_in, coef_wr_in, coef_sel_in;
  logic [3:0] chan_en_in;
  logic [1:0] clock_source_sel_in;
  logic [23:0] raw_code_in, coef_wdata_in, data_out, offset_out, gain_out;
  logic ready_n_out, cont_read_out, converting_out, short_to_neg_out, gpio_tristate_out;
  logic if_busy_out, dout_oe, osc_run;
  logic [7:0] status_out;
  logic [2:0] mode_out;
  logic [31:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  ams_sequencer #(.SETTLE_CYC(1000), .RESET_WAIT_CYC(20)) u_ams_sequencer (
    .clk_in(clk_in), .srst_in(srst_in), .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din),
    .mode_in(mode_in), .mode_wr_in(mode_wr_in), .chan_en_in(chan_en_in),
    .append_status_in(append_status_in), .cont_read_en_in(cont_read_en_in),
    .bipolar_in(bipolar_in), .clock_source_sel_in(clock_source_sel_in),
    .raw_code_in(raw_code_in), .coef_wr_in(coef_wr_in), .coef_sel_in(coef_sel_in),
    .coef_wdata_in(coef_wdata_in), .dout_out(dout), .dout_oe_out(dout_oe),
    .ready_n_out(ready_n_out),
    .status_out(status_out), .data_out(data_out), .offset_out(offset_out),
    .gain_out(gain_out), .mode_out(mode_out), .cont_read_out(cont_read_out),
    .converting_out(converting_out), .short_to_neg_out(short_to_neg_out), .osc_run_out(osc_run),
    .gpio_tristate_out(gpio_tristate_out), .if_busy_out(if_busy_out));
  ams_host_model u_ams_host_model (.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
    .dout_in(dout));
  // 200 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // hang guard, generous over the roughly 9k cycles the sequence needs
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic set_mode(input logic [2:0] m);
    @(negedge clk_in);
    mode_in = m;
    mode_wr_in = 1'b1;
    @(negedge clk_in);
    mode_wr_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask : set_mode
  task automatic coef_wr(input logic sel, input logic [23:0] v);
    @(negedge clk_in);
    coef_sel_in = sel;
    coef_wdata_in = v;
    coef_wr_in = 1'b1;
    @(negedge clk_in);
    coef_wr_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask : coef_wr
  // bounded wait for a fresh result: ready high, then low
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_n_out !== 1'b1 && n < 3000)
    begin
      @(negedge clk_in);
      n++;
    end
    while (ready_n_out !== 1'b0 && n < 3000)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 3000)
      chk({31'h0, ready_n_out}, 32'h0);
    repeat (2) @(negedge clk_in);
  endtask : wait_rdy
  initial
  begin
    srst_in = 1'b1;
    mode_in = MODE_CONT;
    mode_wr_in = 1'b0;
    chan_en_in = 4'h5;
    append_status_in = 1'b0;
    cont_read_en_in = 1'b0;
    bipolar_in = 1'b1;
    clock_source_sel_in = CLKSEL_INT_OSC;
    raw_code_in = 24'h001234;
    coef_wr_in = 1'b0;
    coef_sel_in = 1'b0;
    coef_wdata_in = 24'h0;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    @(negedge clk_in);
    chk({29'h0, mode_out}, 32'h0);
    chk({31'h0, converting_out}, 32'h1);
    chk({8'h0, offset_out}, 32'h800000);
    chk({8'h0, gain_out}, 32'h555555);
    chk({31'h0, dout_oe}, 32'h0);
    set_mode(MODE_PDWN);
    chk({29'h0, mode_out}, 32'h0);
    set_mode(MODE_ICAL_FULL);
    chk({29'h0, mode_out}, 32'h0);
    coef_wr(1'b1, 24'h400000);
    chk({8'h0, gain_out}, 32'h400000);
    wait_rdy();
    chk({8'h0, data_out}, 32'h801234);
    chk({30'h0, status_out[1:0]}, 32'h0);
    u_ams_host_model.xfer(CMD_READ_DATA, 1'b1, 24, rd);
    chk(rd, 32'h801234);
    chk({31'h0, ready_n_out}, 32'h1);
    append_status_in = 1'b1;
    wait_rdy();
    chk({30'h0, status_out[1:0]}, 32'h2);
    u_ams_host_model.xfer(CMD_READ_DATA, 1'b1, 32, rd);
    chk({rd[31:8], 6'h0, rd[1:0]}, 32'h80123402);
    bipolar_in = 1'b0;
    wait_rdy();
    chk({30'h0, status_out[1:0]}, 32'h0);
    chk({8'h0, data_out}, 32'h002468);
    u_ams_host_model.xfer(CMD_READ_DATA, 1'b1, 24, rd);
    // continuous read: clocks alone fetch each result once
    @(negedge clk_in);
    cont_read_en_in = 1'b1;
    repeat (5) @(negedge clk_in);
    chk({31'h0, cont_read_out}, 32'h1);
    wait_rdy();
    u_ams_host_model.xfer(8'h00, 1'b0, 32, rd);
    chk({8'h0, rd[31:8]}, 32'h002468);
    chk({31'h0, ready_n_out}, 32'h1);
    wait_rdy();
    u_ams_host_model.xfer(CMD_READ_DATA, 1'b1, 0, rd);
    repeat (10) @(negedge clk_in);
    chk({31'h0, cont_read_out}, 32'h0);
    cont_read_en_in = 1'b0;
    // single conversion over two channels
    append_status_in = 1'b0;
    bipolar_in = 1'b1;
    chan_en_in = 4'h3;
    set_mode(MODE_SINGLE);
    chk({31'h0, ready_n_out}, 32'h1);
    wait_rdy();
    chk({30'h0, status_out[1:0]}, 32'h0);
    u_ams_host_model.xfer(CMD_READ_DATA, 1'b1, 24, rd);
    wait_rdy();
    chk({30'h0, status_out[1:0]}, 32'h1);
    repeat (5) @(negedge clk_in);
    chk({29'h0, mode_out}, {29'h0, MODE_STBY});
    u_ams_host_model.xfer(CMD_READ_DATA, 1'b1, 24, rd);
    chk(rd, 32'h801234);
    // internal zero-scale calibration, coefficient writes refused meanwhile
    chan_en_in = 4'h1;
    raw_code_in = 24'h000010;
    set_mode(MODE_ICAL_ZERO);
    chk({30'h0, short_to_neg_out, converting_out}, 32'h3);
    chk({31'h0, ready_n_out}, 32'h1);
    coef_wr(1'b0, 24'h123456);
    chk({8'h0, offset_out}, 32'h800000);
    wait_rdy();
    chk({8'h0, offset_out}, 32'h800010);
    chk({29'h0, mode_out}, {29'h0, MODE_STBY});
    chk({31'h0, short_to_neg_out}, 32'h0);
    chk({31'h0, osc_run}, 32'h0);
    clock_source_sel_in = 2'h2;
    repeat (3) @(negedge clk_in);
    chk({31'h0, osc_run}, 32'h1);
    clock_source_sel_in = CLKSEL_INT_OSC;
    // power-down only from standby, left by the serial reset
    set_mode(MODE_PDWN);
    chk({29'h0, mode_out}, {29'h0, MODE_PDWN});
    chk({31'h0, gpio_tristate_out}, 32'h1);
    u_ams_host_model.sreset();
    repeat (3) @(negedge clk_in);
    chk({31'h0, if_busy_out}, 32'h1);
    chk({29'h0, mode_out}, 32'h0);
    chk({8'h0, offset_out}, 32'h800000);
    repeat (25) @(negedge clk_in);
    chk({31'h0, if_busy_out}, 32'h0);
    test_done();
  end
endmodule : ams_sequencer_tb
`default_nettype wire
